//--- hdl/fsp_top.sv
/*
  Flash sector protection controller: apb register slave, sector-checked program and erase
  sequencing, read-out protection with erase-before-unprotect, and pin ownership for the
  in-circuit link. Assumes an external flash array that takes one start pulse per operation
  and answers with a one-cycle done pulse, and a programming tool that owns reset.
*/
//Contract
//- flash holds at most three user sectors, count set by flash size
//- each sector erases alone, other sectors keep their contents
//- sectors zero and one are 4 Kbytes each at the top
//- sector zero spans f000 to ffff and holds the vectors
//- 4K gives sector 0, 8K gives 0 and 1, larger gives 0 to 2
//- read-out protection blocks content extraction and flash writes
//- removing protection first erases all program memory automatically
//- protection set by option bit on flash parts, fixed on mask parts
//- in-application mode may not program or erase sector zero
//- serial clock and data pins leave the application once tool connects
//- link uses reset, ground, clock, data, voltage select, optional clock, supply
//- control/status register at 0024h, reset value 00h
//- program one byte at a time, erase per sector or whole block
`timescale 1ns/1ps
module fsp_top #(
  parameter int FLASH_KB = 60,
  parameter bit MASK_VARIANT = 1'b0,
  parameter bit MASK_PROTECT = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // in-circuit link pins
  input wire logic incircuit_serial_clock_in,
  output logic incircuit_serial_clock_out,
  output logic incircuit_serial_clock_oe,
  input wire logic incircuit_serial_data_in,
  output logic incircuit_serial_data_out,
  output logic incircuit_serial_data_oe,
  input wire logic programming_voltage_select,
  input wire logic tool_present,
  // application use of the shared pins
  input wire logic app_sclk_out,
  input wire logic app_sclk_oe,
  output logic app_sclk_in,
  input wire logic app_sdata_out,
  input wire logic app_sdata_oe,
  output logic app_sdata_in,
  // flash array
  output logic flash_start,
  output fsp_pkg::fsp_op_t flash_op,
  output logic [1:0] flash_sector,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic flash_done,
  input wire logic [7:0] flash_rdata,
  // mode
  output logic incircuit_comm_mode,
  output logic readout_protected
);
  import fsp_pkg::*;

  localparam logic [16:0] FLASH_LO = FSP_SPACE_TOP - 17'(FLASH_KB * 1024);

  logic [3:0] pins_s;
  logic sclk_s, sdata_s, vpp_s, tool_s;
  fsp_state_t state, next_state;
  logic [7:0] ctrl_status, next_ctrl_status;
  logic [15:0] addr_q, next_addr_q;
  logic [7:0] wdata_q, next_wdata_q;
  logic readout_protect_option, next_readout_protect_option;
  logic session, next_session;
  logic [2:0] settle, next_settle;
  logic sclk_prev;
  logic [7:0] rx_shift, next_rx_shift, rx_byte, next_rx_byte;
  logic [2:0] rx_count, next_rx_count;
  logic next_flash_start;
  fsp_op_t next_flash_op, req_op;
  logic [1:0] next_flash_sector, req_sector;
  logic [31:0] next_prdata;
  logic [7:0] rmux;
  logic wr_en, rd_setup, mapped, allowed, in_range, busy;

  // link pins settle in pclk before any use
  fsp_pin_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({tool_present, programming_voltage_select, incircuit_serial_data_in,
          incircuit_serial_clock_in}),
    .pin_sync(pins_s)
  );
  assign {tool_s, vpp_s, sdata_s, sclk_s} = pins_s;

  // apb decode; zero wait states, prdata captured in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign mapped = paddr inside {FSP_CTRL_STATUS_OFF, FSP_ADDR_OFF, FSP_WDATA_OFF,
                                FSP_OPTION_OFF, FSP_LINK_OFF, FSP_RDATA_OFF};
  assign pslverr = psel && penable && !mapped;
  assign busy = ctrl_status[FSP_CS_BUSY];
  assign in_range = {1'b0, addr_q} >= FLASH_LO;
  assign readout_protected = MASK_VARIANT ? MASK_PROTECT : readout_protect_option;
  assign incircuit_comm_mode = session;

  // command taken from a control write: whole-block erase beats sector erase beats program
  always_comb begin
    req_op = FSP_OP_NONE;
    req_sector = pwdata[FSP_CS_SECT_LSB +: 2];
    if (pwdata[FSP_CS_MERASE]) begin
      req_op = FSP_OP_MERASE;
    end else if (pwdata[FSP_CS_SERASE]) begin
      req_op = FSP_OP_SERASE;
    end else if (pwdata[FSP_CS_PROG]) begin
      req_op = FSP_OP_PROG;
      req_sector = fsp_sector_of(addr_q);
    end
  end

  fsp_sector_guard #(.FLASH_KB(FLASH_KB)) u_guard (
    .op(req_op),
    .sector(req_sector),
    .in_range(in_range),
    .app_mode(!session),
    .protected_now(readout_protected),
    .busy(busy),
    .allowed(allowed)
  );

  // pins are handed to the tool as soon as it is plugged in, session or not
  always_comb begin
    incircuit_serial_clock_out = tool_s ? 1'b0 : app_sclk_out;
    incircuit_serial_clock_oe = tool_s ? 1'b0 : app_sclk_oe;
    incircuit_serial_data_out = tool_s ? 1'b0 : app_sdata_out;
    incircuit_serial_data_oe = tool_s ? 1'b0 : app_sdata_oe;
    app_sclk_in = tool_s ? 1'b0 : sclk_s;
    app_sdata_in = tool_s ? 1'b0 : sdata_s;
  end

  // read mux; tool reads of flash contents return zero while protected
  always_comb begin
    rmux = 8'h00;
    case (paddr)
      FSP_CTRL_STATUS_OFF: rmux = ctrl_status;
      FSP_ADDR_OFF: rmux = addr_q[7:0];
      FSP_WDATA_OFF: rmux = wdata_q;
      FSP_OPTION_OFF: rmux = {7'h00, readout_protected};
      FSP_LINK_OFF: rmux = rx_byte;
      FSP_RDATA_OFF: rmux = readout_protected ? 8'h00 : flash_rdata;
      default: rmux = 8'h00;
    endcase
    next_prdata = prdata;
    if (rd_setup) begin
      next_prdata = {24'h000000, rmux};
      if (paddr == FSP_ADDR_OFF) begin
        next_prdata = {16'h0000, addr_q};
      end
    end
  end

  // session strap: taken once the pin chain has settled after reset release
  always_comb begin
    next_settle = settle;
    next_session = session;
    if (settle != FSP_SETTLE_CYCLES) begin
      next_settle = settle + 3'h1;
      if (settle + 3'h1 == FSP_SETTLE_CYCLES) begin
        next_session = vpp_s && tool_s;
      end
    end
  end

  // link receiver: one bit per rising serial clock edge while in session
  always_comb begin
    next_rx_shift = rx_shift;
    next_rx_count = rx_count;
    next_rx_byte = rx_byte;
    if (session && sclk_s && !sclk_prev) begin
      next_rx_shift = {rx_shift[6:0], sdata_s};
      next_rx_count = rx_count + 3'h1;
      if (rx_count == 3'h7) begin
        next_rx_byte = {rx_shift[6:0], sdata_s};
      end
    end
  end

  // register file and operation sequencer; a hardware set wins over a software clear
  always_comb begin
    next_state = state;
    next_ctrl_status = ctrl_status;
    next_addr_q = addr_q;
    next_wdata_q = wdata_q;
    next_readout_protect_option = readout_protect_option;
    next_flash_start = 1'b0;
    next_flash_op = flash_op;
    next_flash_sector = flash_sector;
    if (wr_en) begin
      case (paddr)
        FSP_ADDR_OFF: next_addr_q = pwdata[15:0];
        FSP_WDATA_OFF: next_wdata_q = pwdata[7:0];
        FSP_CTRL_STATUS_OFF: begin
          next_ctrl_status[FSP_CS_SECT_LSB +: 2] = pwdata[FSP_CS_SECT_LSB +: 2];
          if (pwdata[FSP_CS_REFUSED]) begin
            next_ctrl_status[FSP_CS_REFUSED] = 1'b0;
          end
          if (pwdata[FSP_CS_DONE]) begin
            next_ctrl_status[FSP_CS_DONE] = 1'b0;
          end
          if (allowed && state == FSP_ST_IDLE) begin
            next_state = FSP_ST_RUN;
            next_flash_start = 1'b1;
            next_flash_op = req_op;
            next_flash_sector = req_sector;
            next_ctrl_status[FSP_CS_BUSY] = 1'b1;
          end else if (req_op != FSP_OP_NONE) begin
            next_ctrl_status[FSP_CS_REFUSED] = 1'b1;
          end
        end
        FSP_OPTION_OFF: begin
          // option only reprogrammed by the tool, and only on flash parts
          if (!MASK_VARIANT && session && state == FSP_ST_IDLE) begin
            if (pwdata[0]) begin
              next_readout_protect_option = 1'b1;
            end else if (readout_protect_option) begin
              next_state = FSP_ST_UNPROT;
              next_flash_start = 1'b1;
              next_flash_op = FSP_OP_MERASE;
              next_flash_sector = 2'h0;
              next_ctrl_status[FSP_CS_BUSY] = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    case (state)
      FSP_ST_IDLE: ;
      FSP_ST_RUN: begin
        if (flash_done) begin
          next_state = FSP_ST_IDLE;
          next_ctrl_status[FSP_CS_BUSY] = 1'b0;
          next_ctrl_status[FSP_CS_DONE] = 1'b1;
        end
      end
      FSP_ST_UNPROT: begin
        // protection drops only after the whole array is blank
        if (flash_done) begin
          next_state = FSP_ST_IDLE;
          next_readout_protect_option = 1'b0;
          next_ctrl_status[FSP_CS_BUSY] = 1'b0;
          next_ctrl_status[FSP_CS_DONE] = 1'b1;
        end
      end
      default: next_state = FSP_ST_IDLE;
    endcase
  end

  // flash address and data follow the staging registers
  assign flash_addr = addr_q;
  assign flash_wdata = wdata_q;

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FSP_ST_IDLE;
      ctrl_status <= FSP_CTRL_STATUS_RST;
      addr_q <= FSP_ADDR_RST;
      wdata_q <= FSP_WDATA_RST;
      readout_protect_option <= FSP_PROTECT_RST;
      session <= 1'b0;
      settle <= 3'h0;
      sclk_prev <= 1'b0;
      rx_shift <= 8'h00;
      rx_count <= 3'h0;
      rx_byte <= 8'h00;
      flash_start <= 1'b0;
      flash_op <= FSP_OP_NONE;
      flash_sector <= 2'h0;
      prdata <= 32'h00000000;
    end else begin
      state <= next_state;
      ctrl_status <= next_ctrl_status;
      addr_q <= next_addr_q;
      wdata_q <= next_wdata_q;
      readout_protect_option <= next_readout_protect_option;
      session <= next_session;
      settle <= next_settle;
      sclk_prev <= sclk_s;
      rx_shift <= next_rx_shift;
      rx_count <= next_rx_count;
      rx_byte <= next_rx_byte;
      flash_start <= next_flash_start;
      flash_op <= next_flash_op;
      flash_sector <= next_flash_sector;
      prdata <= next_prdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_unprot_start;
    flash_start && flash_op == FSP_OP_MERASE && readout_protected;
  endsequence

  a_busy_after_start: assert property (flash_start |-> busy ##0 !$past(busy))
    else $error("busy not raised with flash start");
  a_iap_sector_zero: assert property (flash_start && !session |-> flash_sector != 2'h0)
    else $error("sector zero touched in application mode");
  a_prog_unprotected: assert property (flash_start && flash_op == FSP_OP_PROG |->
    !readout_protected) else $error("program issued while protected");
  a_unprot_erase: assert property ($fell(readout_protect_option) |->
    $past(flash_done) && $past(state) == FSP_ST_UNPROT) else $error("unprotect without erase");
  a_unprot_holds: assert property (s_unprot_start |=> readout_protected [*2])
    else $error("protection dropped before erase finished");
  a_sector_present: assert property (flash_start |->
    flash_sector < fsp_sectors_present(FLASH_KB)) else $error("absent sector addressed");
  a_top_sector_zero: assert property (flash_start && flash_op == FSP_OP_PROG &&
    flash_addr >= FSP_SECT0_BASE |-> flash_sector == 2'h0) else $error("wrong top sector");
  a_pins_released: assert property (tool_s |-> !incircuit_serial_data_oe &&
    !incircuit_serial_clock_oe && !app_sdata_in) else $error("pins still with application");
  a_ctrl_readback: assert property (psel && !penable && paddr == FSP_CTRL_STATUS_OFF |=>
    prdata[7:0] == $past(ctrl_status)) else $error("control status readback wrong");

endmodule : fsp_top

//--- hdl/fsp_pkg.sv
/*
  Shared constants and types for the flash sector protection block: register offsets,
  control/status field layout, reset values, sector map and the state and operation types.
  Assumes a 16-bit program address space with the flash ending at the top of it.
*/
package fsp_pkg;

  // register offsets, byte addresses on the apb bus
  localparam logic [7:0] FSP_CTRL_STATUS_OFF = 8'h24;
  localparam logic [7:0] FSP_ADDR_OFF = 8'h28;
  localparam logic [7:0] FSP_WDATA_OFF = 8'h2c;
  localparam logic [7:0] FSP_OPTION_OFF = 8'h30;
  localparam logic [7:0] FSP_LINK_OFF = 8'h34;
  localparam logic [7:0] FSP_RDATA_OFF = 8'h38;

  // flash_ctrl_status field positions
  localparam int FSP_CS_PROG = 0;
  localparam int FSP_CS_SERASE = 1;
  localparam int FSP_CS_MERASE = 2;
  localparam int FSP_CS_BUSY = 3;
  localparam int FSP_CS_REFUSED = 4;
  localparam int FSP_CS_SECT_LSB = 5;
  localparam int FSP_CS_DONE = 7;

  // reset values
  localparam logic [7:0] FSP_CTRL_STATUS_RST = 8'h00;
  localparam logic [15:0] FSP_ADDR_RST = 16'h0000;
  localparam logic [7:0] FSP_WDATA_RST = 8'h00;
  localparam logic FSP_PROTECT_RST = 1'b0;

  // sector map: sectors 0 and 1 are 4 Kbytes at the top, sector 2 takes the rest
  localparam logic [15:0] FSP_SECT0_BASE = 16'hf000;
  localparam logic [15:0] FSP_SECT1_BASE = 16'he000;
  localparam int FSP_SMALL_KB = 4;
  localparam int FSP_MID_KB = 8;
  localparam logic [16:0] FSP_SPACE_TOP = 17'h10000;

  // strap taken only after the three-flop chain and its agreement stage have refilled
  localparam logic [2:0] FSP_SETTLE_CYCLES = 3'h5;

  typedef enum logic [1:0] {FSP_OP_NONE, FSP_OP_PROG, FSP_OP_SERASE, FSP_OP_MERASE} fsp_op_t;
  typedef enum logic [1:0] {FSP_ST_IDLE, FSP_ST_RUN, FSP_ST_UNPROT} fsp_state_t;

  // number of user sectors for a given flash size in Kbytes
  function automatic logic [1:0] fsp_sectors_present(input int size_kb);
    if (size_kb <= FSP_SMALL_KB) begin
      return 2'h1;
    end else if (size_kb <= FSP_MID_KB) begin
      return 2'h2;
    end
    return 2'h3;
  endfunction : fsp_sectors_present

  // sector that holds a program address
  function automatic logic [1:0] fsp_sector_of(input logic [15:0] addr);
    if (addr >= FSP_SECT0_BASE) begin
      return 2'h0;
    end else if (addr >= FSP_SECT1_BASE) begin
      return 2'h1;
    end
    return 2'h2;
  endfunction : fsp_sector_of

endpackage : fsp_pkg

//--- hdl/fsp_pin_sync.sv
/*
  Three-flop synchroniser for pins that arrive from outside the pclk domain.
  The output moves only once the second and third flops agree, filtering one-cycle glitches.
  Assumes the pins change no faster than a few pclk periods.
*/
`timescale 1ns/1ps
module fsp_pin_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins and their settled copies
  input wire logic [W-1:0] pin,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_pin_sync;

  // stage1 feeds stage2 only, never any other logic
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_pin_sync[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_sync[i];
    end
  end

  // flop chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      pin_sync <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      pin_sync <= next_pin_sync;
    end
  end

endmodule : fsp_pin_sync

//--- hdl/fsp_sector_guard.sv
/*
  Decides whether a program or erase request may reach the flash array.
  Pure combinational; assumes the caller has already chosen the target sector.
*/
`timescale 1ns/1ps
module fsp_sector_guard #(
  parameter int FLASH_KB = 60
) (
  // request
  input wire fsp_pkg::fsp_op_t op,
  input wire logic [1:0] sector,
  input wire logic in_range,
  // device mode
  input wire logic app_mode,
  input wire logic protected_now,
  input wire logic busy,
  // verdict
  output logic allowed
);
  import fsp_pkg::*;

  localparam logic [1:0] SECTORS = fsp_sectors_present(FLASH_KB);

  // sector zero stays untouched while the application programs itself
  always_comb begin
    allowed = (op != FSP_OP_NONE) && !busy && !protected_now;
    if (sector >= SECTORS) begin
      allowed = 1'b0;
    end
    if (op == FSP_OP_PROG && !in_range) begin
      allowed = 1'b0;
    end
    if (app_mode && (sector == 2'h0 || op == FSP_OP_MERASE)) begin
      allowed = 1'b0;
    end
  end

endmodule : fsp_sector_guard

//--- bench/fsp_tool_model.sv
/*
  Programming tool model: plugs in, straps the session, owns the reset line while
  connected and shifts link bytes on its own clock.
  Assumes pclk from the bench; link timing is unrelated in phase to pclk.
*/
`timescale 1ns/1ps
module fsp_tool_model (
  // bench clock for the reset handshake
  input wire logic pclk,
  // connector side
  output logic tool_present,
  output logic programming_voltage_select,
  output logic tool_rst_n,
  output logic tool_sclk,
  output logic tool_sdata
);
  // unplugged, link clock still, data line not driven by us
  initial begin
    tool_present = 1'b0;
    programming_voltage_select = 1'b0;
    tool_rst_n = 1'b1;
    tool_sclk = 1'b0;
    tool_sdata = 1'b1;
  end

  // strap is raised well before reset so the pin chain has settled
  task automatic plug();
    @(posedge pclk);
    tool_present <= 1'b1;
    programming_voltage_select <= 1'b1;
    repeat (8) @(posedge pclk);
    tool_rst_n <= 1'b0;
    repeat (10) @(posedge pclk);
    tool_rst_n <= 1'b1;
  endtask : plug

  // msb first, 200 ns link period; clock stands low between frames
  task automatic send_byte(input logic [7:0] b);
    int i;
    #37;
    for (i = 7; i >= 0; i--) begin
      tool_sdata = b[i];
      #100;
      tool_sclk = 1'b1;
      #100;
      tool_sclk = 1'b0;
    end
    // released data line shows the inverse so a stale bit is never read as valid
    tool_sdata = ~b[0];
  endtask : send_byte
endmodule : fsp_tool_model

//--- bench/tb.sv
/*
  Self-checking bench for the flash sector protection block: apb master, flash array
  model with a two-cycle done, tool model on the link pins.
  Assumes the 60 Kbyte default map; the apb master waits for pready however long it takes.
*/
`timescale 1ns/1ps
module tb;
  import fsp_pkg::*;
  logic pclk = 1'b0;
  logic por_n, psel, penable, pwrite, flash_done, done_d;
  logic [7:0] paddr;
  logic [7:0] flash_rdata;
  logic [31:0] pwdata;
  logic app_sclk_out, app_sclk_oe, app_sdata_out, app_sdata_oe;
  wire logic presetn, pready, pslverr, flash_start, incircuit_comm_mode, readout_protected;
  wire logic [31:0] prdata;
  wire logic incircuit_serial_clock_in, incircuit_serial_clock_out, incircuit_serial_clock_oe;
  wire logic incircuit_serial_data_in, incircuit_serial_data_out, incircuit_serial_data_oe;
  wire logic programming_voltage_select, tool_present, tool_rst_n, tool_sclk, tool_sdata;
  wire logic app_sclk_in, app_sdata_in;
  wire fsp_op_t flash_op;
  wire logic [1:0] flash_sector;
  wire logic [15:0] flash_addr;
  wire logic [7:0] flash_wdata;
  fsp_op_t last_op;
  logic [1:0] last_sec;
  logic [15:0] last_addr;
  logic [7:0] last_wdata;
  int n_starts = 0;
  int miscompares = 0;
  int n_checks = 0;

  always #12.5 pclk = ~pclk;
  // application reset stays quiet; only the tool pulls reset in a session
  assign presetn = por_n & tool_rst_n;
  // shared pins: device drive first, then the tool, else pull-up
  assign incircuit_serial_clock_in = incircuit_serial_clock_oe ? incircuit_serial_clock_out
                                   : (tool_present ? tool_sclk : 1'b1);
  assign incircuit_serial_data_in = incircuit_serial_data_oe ? incircuit_serial_data_out
                                  : (tool_present ? tool_sdata : 1'b1);

  fsp_top fsp_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .incircuit_serial_clock_in, .incircuit_serial_clock_out,
    .incircuit_serial_clock_oe, .incircuit_serial_data_in, .incircuit_serial_data_out,
    .incircuit_serial_data_oe, .programming_voltage_select, .tool_present, .app_sclk_out,
    .app_sclk_oe, .app_sclk_in, .app_sdata_out, .app_sdata_oe, .app_sdata_in, .flash_start,
    .flash_op, .flash_sector, .flash_addr, .flash_wdata, .flash_done, .flash_rdata,
    .incircuit_comm_mode, .readout_protected);
  fsp_tool_model fsp_tool_model_i (.pclk, .tool_present, .programming_voltage_select,
    .tool_rst_n, .tool_sclk, .tool_sdata);

  // flash array: done two cycles after each start, records what was started
  always @(posedge pclk) begin
    done_d <= flash_start;
    flash_done <= done_d;
    if (flash_start === 1'b1) begin
      n_starts <= n_starts + 1;
      last_op <= flash_op;
      last_sec <= flash_sector;
      last_addr <= flash_addr;
      last_wdata <= flash_wdata;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  // issue one command; either it reaches the array with the right op and sector or is refused
  task automatic run_cmd(input logic [15:0] a, input logic [7:0] c, input bit go,
                         input fsp_op_t op, input logic [1:0] sec);
    int s0;
    logic [31:0] r;
    s0 = n_starts;
    wr(FSP_ADDR_OFF, {16'h0, a});
    wr(FSP_CTRL_STATUS_OFF, {24'h0, c | 8'h90});
    repeat (6) @(posedge pclk);
    rd(FSP_CTRL_STATUS_OFF, r);
    chk("starts", s0 + (go ? 1 : 0), n_starts);
    chk("refused", {31'h0, !go}, {31'h0, r[FSP_CS_REFUSED]});
    if (go) begin
      chk("op", {30'h0, op}, {30'h0, last_op});
      chk("sector", {30'h0, sec}, {30'h0, last_sec});
      chk("addr", {16'h0, a}, {16'h0, last_addr});
    end
  endtask : run_cmd

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(FSP_CTRL_STATUS_OFF, q);
    chk("ctrl_status reset", 32'h0, q);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("protected", 32'h0, {31'h0, readout_protected});
    rd(FSP_RDATA_OFF, q);
    chk("open read", 32'h5a, q);
  endtask : t_reset

  // application mode: sector map and the boot sector lock
  task automatic t_app();
    run_cmd(16'hf000, 8'h01, 1'b0, FSP_OP_PROG, 2'h0);
    run_cmd(16'hefff, 8'h01, 1'b1, FSP_OP_PROG, 2'h1);
    run_cmd(16'he000, 8'h22, 1'b1, FSP_OP_SERASE, 2'h1);
    run_cmd(16'h1000, 8'h01, 1'b1, FSP_OP_PROG, 2'h2);
    run_cmd(16'h0fff, 8'h01, 1'b0, FSP_OP_PROG, 2'h2);
    run_cmd(16'h1000, 8'h02, 1'b0, FSP_OP_SERASE, 2'h0);
    run_cmd(16'h1000, 8'h04, 1'b0, FSP_OP_MERASE, 2'h0);
  endtask : t_app

  task automatic t_pins_app();
    app_sclk_oe <= 1'b1;
    app_sclk_out <= 1'b1;
    app_sdata_oe <= 1'b1;
    app_sdata_out <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("sclk oe app", 32'h1, {31'h0, incircuit_serial_clock_oe});
    chk("sclk out app", 32'h1, {31'h0, incircuit_serial_clock_out});
    chk("sclk to app", 32'h1, {31'h0, app_sclk_in});
    chk("sdata oe app", 32'h1, {31'h0, incircuit_serial_data_oe});
    chk("sdata out app", 32'h1, {31'h0, incircuit_serial_data_out});
    chk("sdata to app", 32'h1, {31'h0, app_sdata_in});
    // clock pin back low so the link stays quiet when the tool arrives
    app_sclk_out <= 1'b0;
  endtask : t_pins_app

  // tool plugged: session, pins taken, link byte, boot sector open
  task automatic t_session();
    logic [31:0] q;
    fsp_tool_model_i.plug();
    repeat (8) @(posedge pclk);
    chk("comm mode", 32'h1, {31'h0, incircuit_comm_mode});
    chk("sclk oe tool", 32'h0, {31'h0, incircuit_serial_clock_oe});
    chk("sclk to app", 32'h0, {31'h0, app_sclk_in});
    chk("sdata oe tool", 32'h0, {31'h0, incircuit_serial_data_oe});
    chk("sdata out tool", 32'h0, {31'h0, incircuit_serial_data_out});
    fsp_tool_model_i.send_byte(8'ha5);
    repeat (10) @(posedge pclk);
    rd(FSP_LINK_OFF, q);
    chk("link byte", 32'ha5, q);
    wr(FSP_WDATA_OFF, 32'h3c);
    run_cmd(16'hf000, 8'h01, 1'b1, FSP_OP_PROG, 2'h0);
    chk("wdata", 32'h3c, {24'h0, last_wdata});
  endtask : t_session

  // protect, then unprotect which must erase everything first
  task automatic t_protect();
    logic [31:0] q;
    int s0;
    wr(FSP_OPTION_OFF, 32'h1);
    repeat (3) @(posedge pclk);
    chk("protected on", 32'h1, {31'h0, readout_protected});
    rd(FSP_RDATA_OFF, q);
    chk("hidden read", 32'h0, q);
    run_cmd(16'he000, 8'h01, 1'b0, FSP_OP_PROG, 2'h1);
    s0 = n_starts;
    wr(FSP_OPTION_OFF, 32'h0);
    repeat (8) @(posedge pclk);
    chk("erase starts", s0 + 1, n_starts);
    chk("erase op", {30'h0, FSP_OP_MERASE}, {30'h0, last_op});
    chk("protected off", 32'h0, {31'h0, readout_protected});
  endtask : t_protect

  task automatic conclude();
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // all inputs defined at time zero, then the run
  initial begin
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    flash_done = 1'b0;
    done_d = 1'b0;
    flash_rdata = 8'h5a;
    app_sclk_out = 1'b1;
    app_sclk_oe = 1'b0;
    app_sdata_out = 1'b0;
    app_sdata_oe = 1'b0;
    repeat (10) @(posedge pclk);
    por_n <= 1'b1;
    t_reset();
    t_app();
    t_pins_app();
    t_session();
    t_protect();
    conclude();
  end

  // the whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    conclude();
  end
endmodule : tb
